// >>> hw/counter_array_regs.svh
`ifndef COUNTER_ARRAY_REGS_SVH
`define COUNTER_ARRAY_REGS_SVH
// register offsets
`define CA_OFS_LOW 8'h00
`define CA_OFS_HIGH 8'h01
`define CA_OFS_MODE 8'h02
`define CA_OFS_CTRL 8'h03
`define CA_OFS_CHEN 8'h04
`define CA_OFS_PWM_CYCLE_LENGTH_SELECT 8'h05
`define CA_OFS_CHFLAG 8'h06
// mode register fields
`define CA_MODE_ECF 0
`define CA_MODE_CPS_LO 1
`define CA_MODE_CPS_HI 3
`define CA_MODE_WDT 6
`define CA_MODE_IDLE_SUSPEND 7
// control register fields
`define CA_CTRL_CF 7
`define CA_CTRL_INTERMEDIATE_OVERFLOW_FLAG 6
`define CA_CTRL_INTERMEDIATE_OVERFLOW_IRQ_ENABLE 5
`define CA_CTRL_ARR_EN 0
// reset values
`define CA_MODE_RESET 8'h40
`define CA_ZERO_BYTE 8'h00
// divider counts
`define CA_DIV12_LAST 4'hB
`define CA_DIV4_LAST 4'h3
`endif

// >>> hw/counter_array_pkg.sv
`default_nettype none
package counter_array_pkg;
  typedef enum logic [2:0] {
    TB_DIV12, TB_DIV4, TB_T0OVF, TB_EXT_EDGE, TB_SYSCLK, TB_XOSC8, TB_RTC8, TB_RESERVED
  } timebase_type;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;
endpackage
`default_nettype wire

// >>> hw/counter_array_timebase_irq.sv
// Notes on behaviour
// - one 16-bit counter as two bytes
// - low read latches high byte snapshot
// - reads never disturb counting
// - three-bit field selects count source
// - divided oscillator sources synchronised first
// - wrap to zero sets overflow flag
// - overflow request only when enabled
// - overflow flag cleared only by software
// - normal counting in idle when allowed
// - intermediate flag on lower bit overflow
// - six channel flags set by modules
// - flags set regardless of enables
// - request is OR of enabled flags
// - request needs global and array enables
// - six channel lines gated by crossbar
// - module five watchdog locks writes
// - cycle length picks intermediate bit
// - channel flags cleared only by software
`include "counter_array_regs.svh"
`default_nettype none
module counter_array_timebase_irq
  import counter_array_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic CPU_IDLE,
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic TIMER0_OVF,
  input wire logic EXT_COUNT_INPUT,
  input wire logic XOSC_DIV8,
  input wire logic RTC_DIV8,
  input wire logic [5:0] CHANNEL_MATCH_SET,
  input wire logic [5:0] CHANNEL_OUT,
  input wire logic [5:0] CROSSBAR_ENABLE,
  output logic [5:0] CHANNEL_IO_LINE,
  output logic [5:0] CHANNEL_IO_LINE_OE,
  output logic [15:0] COUNT_VALUE,
  output logic COUNT_TICK,
  output logic WATCHDOG_MODE,
  output logic IRQ
);
  bus_req_type req;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic [7:0] snap_q;
  logic [7:0] mode_q;
  logic cf_q;
  logic intermediate_overflow_flag_q;
  logic intermediate_overflow_irq_enable_q;
  logic arr_en_q;
  logic [5:0] chen_q;
  logic [5:0] chflag_q;
  logic [1:0] pwm_cycle_length_select_q;
  logic [3:0] div_q;
  logic div12_tick;
  logic div4_tick;
  logic ext_d1_q;
  logic ext_d2_q;
  logic xo_rise;
  logic rt_rise;
  logic tick;
  logic run;
  logic wrap;
  logic inter_ovf;
  logic irq_any;
  timebase_type tb;

  // bundle the register port
  assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
  assign tb = timebase_type'(mode_q[`CA_MODE_CPS_HI:`CA_MODE_CPS_LO]);

  // free running prescaler for the /12 and /4 sources
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      div_q <= 4'h0;
    end else if (div_q == `CA_DIV12_LAST) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end
  assign div12_tick = (div_q == `CA_DIV12_LAST);
  assign div4_tick = ({2'b00, div_q[1:0]} == `CA_DIV4_LAST);

  // external pin edge detector, input assumed synchronous
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      ext_d1_q <= 1'b1;
      ext_d2_q <= 1'b1;
    end else begin
      ext_d1_q <= EXT_COUNT_INPUT;
      ext_d2_q <= ext_d1_q;
    end
  end

  // synchronisers for the divided oscillator sources
  counter_array_rise_sync #(.STAGES(3)) xo_sync (
    .clk(CORE_CLK),
    .rst(RESET),
    .level(XOSC_DIV8),
    .rise(xo_rise)
  );
  counter_array_rise_sync #(.STAGES(3)) rt_sync (
    .clk(CORE_CLK),
    .rst(RESET),
    .level(RTC_DIV8),
    .rise(rt_rise)
  );

  // count source multiplexer
  always_comb begin
    case (tb)
      TB_DIV12: tick = div12_tick;
      TB_DIV4: tick = div4_tick;
      TB_T0OVF: tick = TIMER0_OVF;
      TB_EXT_EDGE: tick = ext_d2_q & ~ext_d1_q;
      TB_SYSCLK: tick = 1'b1;
      TB_XOSC8: tick = xo_rise;
      TB_RTC8: tick = rt_rise;
      TB_RESERVED: tick = 1'b0;
      default: tick = 1'b0;
    endcase
  end

  // idle suspend gates counting
  assign run = tick & ~(mode_q[`CA_MODE_IDLE_SUSPEND] & CPU_IDLE);
  assign count_d = count_q + 16'h0001;
  assign wrap = run & (count_q == 16'hFFFF);

  // intermediate overflow at bit chosen by cycle length
  always_comb begin
    case (pwm_cycle_length_select_q)
      2'b00: inter_ovf = run & (count_q[7:0] == 8'hFF);
      2'b01: inter_ovf = run & (count_q[8:0] == 9'h1FF);
      2'b10: inter_ovf = run & (count_q[9:0] == 10'h3FF);
      2'b11: inter_ovf = run & (count_q[10:0] == 11'h7FF);
      default: inter_ovf = 1'b0;
    endcase
  end

  // the counter itself; register reads never touch it
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      count_q <= 16'h0000;
    end else if (req.wr && req.addr == `CA_OFS_LOW && !mode_q[`CA_MODE_WDT]) begin
      count_q <= {count_q[15:8], req.wdata};
    end else if (req.wr && req.addr == `CA_OFS_HIGH && !mode_q[`CA_MODE_WDT]) begin
      count_q <= {req.wdata, count_q[7:0]};
    end else if (run) begin
      count_q <= count_d;
    end
  end

  // high byte snapshot on low byte read
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      snap_q <= `CA_ZERO_BYTE;
    end else if (req.rd && req.addr == `CA_OFS_LOW) begin
      snap_q <= count_q[15:8];
    end
  end

  // mode register; watchdog bit locks the rest
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      mode_q <= `CA_MODE_RESET;
    end else if (req.wr && req.addr == `CA_OFS_MODE) begin
      if (mode_q[`CA_MODE_WDT]) begin
        mode_q[`CA_MODE_WDT] <= req.wdata[`CA_MODE_WDT];
      end else begin
        mode_q <= {req.wdata[7:6], 2'b00, req.wdata[3:0]};
      end
    end
  end

  // control register enables
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      intermediate_overflow_irq_enable_q <= 1'b0;
      arr_en_q <= 1'b0;
    end else if (req.wr && req.addr == `CA_OFS_CTRL) begin
      intermediate_overflow_irq_enable_q <= req.wdata[`CA_CTRL_INTERMEDIATE_OVERFLOW_IRQ_ENABLE];
      arr_en_q <= req.wdata[`CA_CTRL_ARR_EN];
    end
  end

  // per-channel interrupt enables
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      chen_q <= 6'h00;
    end else if (req.wr && req.addr == `CA_OFS_CHEN) begin
      chen_q <= req.wdata[5:0];
    end
  end

  // cycle length, locked while the watchdog runs
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      pwm_cycle_length_select_q <= 2'b00;
    end else if (req.wr && req.addr == `CA_OFS_PWM_CYCLE_LENGTH_SELECT && !mode_q[`CA_MODE_WDT]) begin
      pwm_cycle_length_select_q <= req.wdata[1:0];
    end
  end

  // sticky overflow flag; hardware set beats software clear
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      cf_q <= 1'b0;
    end else if (wrap) begin
      cf_q <= 1'b1;
    end else if (req.wr && req.addr == `CA_OFS_CTRL) begin
      cf_q <= req.wdata[`CA_CTRL_CF];
    end
  end

  // sticky intermediate flag; hardware set beats software clear
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      intermediate_overflow_flag_q <= 1'b0;
    end else if (inter_ovf) begin
      intermediate_overflow_flag_q <= 1'b1;
    end else if (req.wr && req.addr == `CA_OFS_CTRL) begin
      intermediate_overflow_flag_q <= req.wdata[`CA_CTRL_INTERMEDIATE_OVERFLOW_FLAG];
    end
  end

  // channel flags from the capture/compare modules
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      chflag_q <= 6'h00;
    end else if (req.wr && req.addr == `CA_OFS_CHFLAG) begin
      chflag_q <= (chflag_q & req.wdata[5:0]) | CHANNEL_MATCH_SET;
    end else begin
      chflag_q <= chflag_q | CHANNEL_MATCH_SET;
    end
  end

  // combined request
  assign irq_any = (cf_q & mode_q[`CA_MODE_ECF]) | (intermediate_overflow_flag_q & intermediate_overflow_irq_enable_q) | (|(chflag_q & chen_q));

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= irq_any & arr_en_q & GLOBAL_IRQ_ENABLE;
    end
  end

  // channel lines through the crossbar
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      CHANNEL_IO_LINE <= 6'h00;
    end else begin
      CHANNEL_IO_LINE <= CHANNEL_OUT & CROSSBAR_ENABLE;
    end
  end

  // a line is driven only where the crossbar routes it
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      CHANNEL_IO_LINE_OE <= 6'h00;
    end else begin
      CHANNEL_IO_LINE_OE <= CROSSBAR_ENABLE;
    end
  end

  // counter value to the compare modules
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      COUNT_VALUE <= 16'h0000;
    end else begin
      COUNT_VALUE <= count_q;
    end
  end

  // tick marks a count step, one cycle ahead of the value
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      COUNT_TICK <= 1'b0;
    end else begin
      COUNT_TICK <= run;
    end
  end

  // watchdog state for the channel five logic
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      WATCHDOG_MODE <= 1'b1;
    end else begin
      WATCHDOG_MODE <= mode_q[`CA_MODE_WDT];
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      RDATA <= `CA_ZERO_BYTE;
    end else if (req.rd) begin
      case (req.addr)
        `CA_OFS_LOW: RDATA <= count_q[7:0];
        `CA_OFS_HIGH: RDATA <= snap_q;
        `CA_OFS_MODE: RDATA <= {mode_q[7:6], 2'b00, mode_q[3:0]};
        `CA_OFS_CTRL: RDATA <= {cf_q, intermediate_overflow_flag_q, intermediate_overflow_irq_enable_q, 4'h0, arr_en_q};
        `CA_OFS_CHEN: RDATA <= {2'b00, chen_q};
        `CA_OFS_PWM_CYCLE_LENGTH_SELECT: RDATA <= {6'h00, pwm_cycle_length_select_q};
        `CA_OFS_CHFLAG: RDATA <= {2'b00, chflag_q};
        default: RDATA <= `CA_ZERO_BYTE;
      endcase
    end else begin
      RDATA <= `CA_ZERO_BYTE;
    end
  end
endmodule

// shift a slow level into the clock domain and flag its rise
module counter_array_rise_sync
  import counter_array_pkg::*;
#(
  parameter int STAGES = 3
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic level,
  output logic rise
);
  logic [STAGES-1:0] pipe_q;

  // only the last two stages are looked at, never the first
  always_ff @(posedge clk) begin
    if (rst) begin
      pipe_q <= '0;
    end else begin
      pipe_q <= {pipe_q[STAGES-2:0], level};
    end
  end
  assign rise = pipe_q[STAGES-2] & ~pipe_q[STAGES-1];
endmodule
`default_nettype wire

// >>> bench/counter_array_monitor.sv
`default_nettype none
module counter_array_monitor (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic [7:0] ADDR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic [5:0] CHANNEL_OUT,
  input wire logic [5:0] CROSSBAR_ENABLE,
  input wire logic [5:0] CHANNEL_IO_LINE,
  input wire logic [15:0] COUNT_VALUE,
  input wire logic COUNT_TICK,
  input wire logic WATCHDOG_MODE,
  input wire logic IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  // read port, counter and routing relations
  rd_quiet_a: assert property (!$past(RD) |-> RDATA == 8'h00) else $error("data without read");
  low_read_a: assert property (RD && ADDR == 8'h00 |=> RDATA == COUNT_VALUE[7:0])
    else $error("low byte wrong");
  snap_read_a: assert property (RD && ADDR == 8'h00 ##1 RD && ADDR == 8'h01 |=>
    {8'h00, RDATA} == $past(COUNT_VALUE) >> 8) else $error("snapshot wrong");
  tick_step_a: assert property ($past(COUNT_TICK) |-> COUNT_VALUE == $past(COUNT_VALUE) + 16'h0001)
    else $error("tick not plus one");
  no_tick_a: assert property (!$past(COUNT_TICK) |-> $stable(COUNT_VALUE)) else $error("count moved");
  irq_gate_a: assert property (!$past(GLOBAL_IRQ_ENABLE) |-> !IRQ) else $error("irq ungated");
  io_route_a: assert property (!$past(RESET) |->
    CHANNEL_IO_LINE == ($past(CHANNEL_OUT) & $past(CROSSBAR_ENABLE))) else $error("io line wrong");
  wd_start_a: assert property ($past(RESET) |-> WATCHDOG_MODE) else $error("watchdog off");
  tick_c: cover property (COUNT_TICK);
  irq_c: cover property ($rose(IRQ));
  wd_off_c: cover property ($fell(WATCHDOG_MODE));
endmodule
bind counter_array_timebase_irq counter_array_monitor mon (.CORE_CLK, .RESET, .ADDR, .RD, .RDATA,
  .GLOBAL_IRQ_ENABLE, .CHANNEL_OUT, .CROSSBAR_ENABLE, .CHANNEL_IO_LINE, .COUNT_VALUE, .COUNT_TICK,
  .WATCHDOG_MODE, .IRQ);
`default_nettype wire

// >>> bench/count_source_model.sv
`default_nettype none
module count_source_model (
  input wire logic clk,
  input wire logic rst,
  output logic t0_ovf,
  output logic ext_in,
  output logic xosc,
  output logic rtc
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] phase_q;
  // free-running phase paces every source
  always_ff @(posedge clk) begin
    phase_q <= rst ? 5'h00 : phase_q + 5'h01;
  end
  assign t0_ovf = phase_q[3:0] == 4'hF;
  assign ext_in = phase_q[2];
  assign xosc = phase_q[3];
  assign rtc = phase_q[4];
endmodule
`default_nettype wire

// >>> bench/counter_array_timebase_irq_bench.sv
`default_nettype none
module counter_array_timebase_irq_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic CORE_CLK = 1'b0;
  logic RESET = 1'b1;
  logic [7:0] ADDR = 8'h00;
  logic [7:0] WDATA = 8'h00;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic CPU_IDLE = 1'b0;
  logic GLOBAL_IRQ_ENABLE = 1'b0;
  logic [5:0] CHANNEL_MATCH_SET = 6'h00;
  logic [5:0] CHANNEL_OUT = 6'h00;
  logic [5:0] CROSSBAR_ENABLE = 6'h00;
  logic [7:0] RDATA;
  logic [5:0] CHANNEL_IO_LINE;
  logic [5:0] CHANNEL_IO_LINE_OE;
  logic WATCHDOG_MODE;
  logic [15:0] COUNT_VALUE;
  logic TIMER0_OVF, EXT_COUNT_INPUT, XOSC_DIV8, RTC_DIV8, COUNT_TICK, IRQ;
  int failures = 0;
  int n_tests = 0;
  int n;
  int exp_ticks[8] = '{8, 24, 6, 12, 96, 6, 3, 0};
  always #10 CORE_CLK = ~CORE_CLK;
  counter_array_timebase_irq dut (.CORE_CLK, .RESET, .ADDR, .WDATA, .WR, .RD, .RDATA, .CPU_IDLE,
    .GLOBAL_IRQ_ENABLE, .TIMER0_OVF, .EXT_COUNT_INPUT, .XOSC_DIV8, .RTC_DIV8, .CHANNEL_MATCH_SET,
    .CHANNEL_OUT, .CROSSBAR_ENABLE, .CHANNEL_IO_LINE, .CHANNEL_IO_LINE_OE, .COUNT_VALUE, .COUNT_TICK,
    .WATCHDOG_MODE, .IRQ);
  count_source_model src (.clk(CORE_CLK), .rst(RESET), .t0_ovf(TIMER0_OVF), .ext_in(EXT_COUNT_INPUT),
    .xosc(XOSC_DIV8), .rtc(RTC_DIV8));
  // compare and bus helpers
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge CORE_CLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CORE_CLK);
    WR <= 1'b0;
  endtask
  task automatic rc(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge CORE_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CORE_CLK);
    RD <= 1'b0;
    #1 chk(what, {8'h00, RDATA}, {8'h00, exp});
  endtask
  // ticks over a window that is a whole number of source periods
  task automatic meas(input logic [7:0] mode, input int exp);
    wr(8'h02, mode);
    repeat (32) @(posedge CORE_CLK);
    n = 0;
    repeat (96) begin
      @(posedge CORE_CLK);
      #1 n += COUNT_TICK;
    end
    chk("ticks", n[15:0], exp[15:0]);
  endtask
  task automatic irq_is(input logic exp);
    repeat (3) @(posedge CORE_CLK);
    #1 chk("irq", {15'h0000, IRQ}, {15'h0000, exp});
  endtask
  task automatic wirq(input int lim);
    n = 0;
    while (IRQ !== 1'b1 && n < lim) begin
      @(posedge CORE_CLK);
      #1;
      n++;
    end
  endtask
  task automatic complete_run;
    if (failures == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // hang guard
  initial begin
    #1900000;
    failures++;
    complete_run();
  end
  // main sequence
  initial begin
    repeat (3) @(posedge CORE_CLK);
    RESET <= 1'b0;
    CROSSBAR_ENABLE <= 6'h2A;
    CHANNEL_OUT <= 6'h3C;
    rc("mode", 8'h02, 8'h40);
    rc("ctrl", 8'h03, 8'h00);
    rc("unmapped", 8'h3F, 8'h00);
    wr(8'h05, 8'h03);
    wr(8'h02, 8'hC8);
    rc("len lock", 8'h05, 8'h00);
    rc("mode lock", 8'h02, 8'h40);
    chk("io line", {10'h000, CHANNEL_IO_LINE}, 16'h0028);
    chk("io enable", {10'h000, CHANNEL_IO_LINE_OE}, 16'h002A);
    chk("watchdog on", {15'h0000, WATCHDOG_MODE}, 16'h0001);
    for (int t = 0; t < 8; t++) begin
      meas({4'h0, t[2:0], 1'b0}, exp_ticks[t]);
    end
    @(posedge CORE_CLK);
    CPU_IDLE <= 1'b1;
    meas(8'h08, 96);
    meas(8'h88, 0);
    chk("watchdog off", {15'h0000, WATCHDOG_MODE}, 16'h0000);
    CPU_IDLE <= 1'b0;
    @(posedge CORE_CLK);
    RD <= 1'b1;
    ADDR <= 8'h00;
    @(posedge CORE_CLK);
    ADDR <= 8'h01;
    @(posedge CORE_CLK);
    RD <= 1'b0;
    GLOBAL_IRQ_ENABLE <= 1'b1;
    wr(8'h03, 8'h01);
    CHANNEL_MATCH_SET <= 6'h3F;
    @(posedge CORE_CLK);
    CHANNEL_MATCH_SET <= 6'h00;
    rc("flags", 8'h06, 8'h3F);
    irq_is(1'b0);
    wr(8'h04, 8'h01);
    irq_is(1'b1);
    GLOBAL_IRQ_ENABLE <= 1'b0;
    irq_is(1'b0);
    GLOBAL_IRQ_ENABLE <= 1'b1;
    wr(8'h03, 8'h00);
    irq_is(1'b0);
    wr(8'h03, 8'h01);
    wr(8'h06, 8'h3E);
    irq_is(1'b0);
    rc("flags", 8'h06, 8'h3E);
    wr(8'h04, 8'h00);
    wr(8'h02, 8'h09);
    wr(8'h03, 8'h01);
    wirq(70000);
    chk("wrap irq", {15'h0000, IRQ}, 16'h0001);
    irq_is(1'b1);
    rc("ctrl", 8'h03, 8'hC1);
    wr(8'h02, 8'h08);
    wr(8'h05, 8'h03);
    wr(8'h03, 8'h21);
    wirq(3000);
    wr(8'h03, 8'h21);
    irq_is(1'b0);
    wirq(3000);
    chk("long cycle", {15'h0000, n > 1800 && n < 2100}, 16'h0001);
    complete_run();
  end
endmodule
`default_nettype wire
